// [core/seq_pkg.sv]
// Package: constants for the capture sequencer skip/jump/sync decoder
// Operation
// - Packed skip drops byte count from queue
// - Packed skip may start mid word
// - Planar skip drops luma count from word0
// - Planar chroma counts come from word1 fields
// - Planar skip keeps byte position per queue
// - Jump loads aligned address from word1
// - Jump is always taken, never conditional
// - Sync drops data until status tag matches
// - Sync bit 15 hides realign errors
// - Before match, discard data; after, resume
// - Bad opcode or status: interrupt and halt
// - Early line end aborts through flagged skip
`default_nettype none
package seq_pkg;
   // -----------------------------------------------------------
   // Opcodes and instruction fields
   // -----------------------------------------------------------
   localparam logic [3:0] OP_SKIP = 4'h2;
   localparam logic [3:0] OP_PLANAR = 4'ha;
   localparam logic [3:0] OP_JUMP = 4'h7;
   localparam logic [3:0] OP_SYNC = 4'h8;
   localparam int CNT_W = 12;
   localparam int F_OP_LSB = 28;
   localparam int F_LSTART = 27;
   localparam int F_LEND = 26;
   localparam int F_IRQ = 24;
   localparam int F_SET_LSB = 20;
   localparam int F_CLR_LSB = 16;
   localparam int F_CNT3_LSB = 16;
   localparam int F_SUPP = 15;
   localparam logic [15:0] SYNC_LEGAL = 16'h7fff;
   localparam logic [2:0] DW_BYTES = 3'h4;
   localparam logic [31:0] PC_STEP = 32'h4;
   // -----------------------------------------------------------
   // Registers
   // -----------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_START = 8'h04;
   localparam logic [7:0] REG_PC = 8'h08;
   localparam logic [7:0] REG_RUNSTAT = 8'h0c;
   localparam logic [7:0] REG_ISTAT = 8'h10;
   localparam logic [7:0] REG_IMASK = 8'h14;
   localparam int CTRL_EN = 0;
   localparam int RS_RUN = 8;
   localparam int RS_HALT = 9;
   localparam logic [31:0] PC_RST = 32'h0;
   localparam logic [3:0] PSTAT_RST = 4'h0;
   // -----------------------------------------------------------
   // Interrupt events
   // -----------------------------------------------------------
   localparam int EV_N = 4;
   localparam int EV_INSTR = 0;
   localparam int EV_BAD = 1;
   localparam int EV_REALIGN = 2;
   localparam int EV_ABORT = 3;
   localparam logic [EV_N-1:0] MASK_RST = 4'h0;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_FETCH0 = 5'b00010,
      S_FETCH1 = 5'b00100,
      S_EXEC = 5'b01000,
      S_HALT = 5'b10000
   } state_t;
endpackage
`default_nettype wire

// [core/event_flags.sv]
// Sticky interrupt status with mask and level output
`timescale 1ns/1ps
`default_nettype none
module event_flags import seq_pkg::*; #(
   parameter int N = EV_N
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [N-1:0] set_i,
   input wire logic [N-1:0] clr_i,
   input wire logic [N-1:0] mask_i,
   output logic [N-1:0] stat_o,
   output logic irq_o
);
   typedef struct packed {
      logic [N-1:0] stat;
      logic irq;
   } ev_t;
   ev_t q;
   ev_t d;
   always_comb begin
      d = q;
      // Set wins over a write-one clear
      d.stat = (q.stat & ~clr_i) | set_i;
      d.irq = |(d.stat & mask_i);
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign stat_o = q.stat;
   assign irq_o = q.irq;
endmodule
`default_nettype wire

// [core/queue_byte_skipper.sv]
// Byte-accurate discard engine for one pixel queue
`timescale 1ns/1ps
`default_nettype none
module queue_byte_skipper import seq_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [CNT_W-1:0] cnt_i,
   input wire logic flush_i,
   input wire logic drop_i,
   input wire logic valid_i,
   input wire logic line_end_i,
   output logic pop_o,
   output logic early_o,
   output logic idle_o
);
   typedef struct packed {
      logic [CNT_W-1:0] rem;
      logic [1:0] off;
      logic pop;
      logic early;
   } sk_t;
   sk_t q;
   sk_t d;
   logic [2:0] avail;
   logic [2:0] take;
   logic [2:0] sum;
   logic [1:0] sum_lo;
   logic step;
   always_comb begin
      d = q;
      d.pop = 1'b0;
      d.early = 1'b0;
      avail = DW_BYTES - {1'b0, q.off};
      take = (q.rem < {9'h0, avail}) ? q.rem[2:0] : avail;
      sum = {1'b0, q.off} + take;
      sum_lo = sum[1:0];
      step = !start_i && !flush_i && !drop_i && valid_i && !q.pop
         && (q.rem != '0);
      if (start_i) begin
         d.rem = cnt_i;
      end else if (flush_i) begin
         d.rem = '0;
      end else if (!q.pop && valid_i) begin
         if (drop_i) begin
            d.pop = 1'b1;
            d.off = 2'h0;
         end else if (q.rem != '0) begin
            // Take up to what is left of the current word
            d.rem = q.rem - {9'h0, take};
            if (sum == DW_BYTES) begin
               d.pop = 1'b1;
               d.off = 2'h0;
               if (line_end_i && d.rem != '0) begin
                  d.early = 1'b1;
                  d.rem = '0;
               end
            end else begin
               d.off = sum_lo;
            end
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign pop_o = q.pop;
   assign early_o = q.early;
   assign idle_o = (q.rem == '0) && !q.pop;
   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_off_track: assert property (
      step && sum != DW_BYTES |=> !q.pop && q.off == $past(sum_lo)
      && q.rem == $past(q.rem) - {9'h0, $past(take)})
      else $error("byte offset not tracked");
   a_wrap_pop: assert property (
      step && sum == DW_BYTES |=> q.pop ##1 !q.pop)
      else $error("word end not popped once");
endmodule
`default_nettype wire

// [core/seq_skip_jump_sync.sv]
// Sequencer decoder: packed/planar skip, jump and stream sync
`timescale 1ns/1ps
`default_nettype none
module seq_skip_jump_sync import seq_pkg::*; (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O,
   output logic INSTR_REQ_O,
   output logic [31:0] INSTR_ADDR_O,
   input wire logic INSTR_ACK_I,
   input wire logic [31:0] INSTR_DATA_I,
   input wire logic [2:0] Q_VALID_I,
   output logic [2:0] Q_POP_O,
   input wire logic [3:0] LUMA_TAG_I,
   input wire logic LUMA_LINE_END_I,
   output logic [3:0] PROG_STATUS_O,
   output logic IRQ_O
);

   // -----------------------------------------------------------
   // Decode helpers
   // -----------------------------------------------------------
   function automatic logic op_bad(input logic [31:0] w);
      logic [3:0] op;
      op = w[F_OP_LSB +: 4];
      op_bad = 1'b1;
      if (op == OP_SKIP || op == OP_PLANAR || op == OP_JUMP) begin
         op_bad = 1'b0;
      end else if (op == OP_SYNC) begin
         op_bad = !SYNC_LEGAL[w[3:0]];
      end
   endfunction

   function automatic logic op_is_skip(input logic [31:0] w);
      op_is_skip = (w[F_OP_LSB +: 4] == OP_SKIP)
         || (w[F_OP_LSB +: 4] == OP_PLANAR);
   endfunction

   // -----------------------------------------------------------
   // State
   // -----------------------------------------------------------
   typedef struct packed {
      state_t st;
      logic [31:0] pc;
      logic [31:0] dw0;
      logic [31:0] dw1;
      logic req;
      logic first;
      logic abort;
      logic en;
      logic go;
      logic [31:0] start;
      logic [EV_N-1:0] mask;
      logic [3:0] pstat;
      logic [31:0] rdata;
   } top_t;

   top_t q;
   top_t d;
   logic [3:0] op;
   logic done;
   logic [3:0] pstat_nx;
   logic [EV_N-1:0] ev;
   logic [EV_N-1:0] clr;
   logic [EV_N-1:0] ev_stat;
   logic [2:0] sk_start;
   logic sk_flush;
   logic sk_drop;
   logic [2:0] sk_idle;
   logic [2:0] sk_early;
   logic [2:0][CNT_W-1:0] sk_cnt;
   logic [2:0] drop_v;
   logic [2:0] line_end_v;
   logic tag_hit;
   logic sync_ready;
   logic [31:0] jump_tgt;

   assign op = q.dw0[F_OP_LSB +: 4];
   assign tag_hit = (LUMA_TAG_I == q.dw0[3:0]);
   assign jump_tgt = {INSTR_DATA_I[31:2], 2'b00};
   assign pstat_nx = (q.pstat & ~q.dw0[F_CLR_LSB +: 4])
      | q.dw0[F_SET_LSB +: 4];
   assign sync_ready = (q.st == S_EXEC) && (op == OP_SYNC) && !q.first
      && sk_idle[0] && Q_VALID_I[0];
   assign sk_cnt[0] = q.dw0[CNT_W-1:0];
   assign sk_cnt[1] = q.dw1[CNT_W-1:0];
   assign sk_cnt[2] = q.dw1[F_CNT3_LSB +: CNT_W];
   assign drop_v = {2'b00, sk_drop};
   assign line_end_v = {2'b00, LUMA_LINE_END_I};

   // -----------------------------------------------------------
   // Next state
   // -----------------------------------------------------------
   always_comb begin
      d = q;
      d.go = 1'b0;
      d.rdata = '0;
      ev = '0;
      clr = '0;
      done = 1'b0;
      sk_start = 3'b000;
      sk_flush = 1'b0;
      sk_drop = 1'b0;

      // Register writes
      if (REG_WR_I) begin
         case (REG_ADDR_I)
            REG_CTRL: begin
               d.en = REG_WDATA_I[CTRL_EN];
               d.go = REG_WDATA_I[CTRL_EN];
            end
            REG_START: begin
               d.start = REG_WDATA_I;
            end
            REG_ISTAT: begin
               clr = REG_WDATA_I[EV_N-1:0];
            end
            REG_IMASK: begin
               d.mask = REG_WDATA_I[EV_N-1:0];
            end
            default: begin
            end
         endcase
      end

      // Register reads, data in the next cycle
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            REG_CTRL: begin
               d.rdata[CTRL_EN] = q.en;
            end
            REG_START: begin
               d.rdata = q.start;
            end
            REG_PC: begin
               d.rdata = q.pc;
            end
            REG_RUNSTAT: begin
               d.rdata[3:0] = q.pstat;
               d.rdata[RS_RUN] = !(q.st == S_IDLE || q.st == S_HALT);
               d.rdata[RS_HALT] = (q.st == S_HALT);
            end
            REG_ISTAT: begin
               d.rdata[EV_N-1:0] = ev_stat;
            end
            REG_IMASK: begin
               d.rdata[EV_N-1:0] = q.mask;
            end
            default: begin
            end
         endcase
      end

      // Sequencer
      case (q.st)
         S_IDLE, S_HALT: begin
            // Restart from the start address when enabled
            if (q.go) begin
               d.pc = q.start;
               d.st = S_FETCH0;
               d.req = 1'b1;
               d.abort = 1'b0;
            end
         end
         S_FETCH0: begin
            if (INSTR_ACK_I) begin
               d.req = 1'b0;
               d.dw0 = INSTR_DATA_I;
               d.pc = q.pc + PC_STEP;
               if (!q.en) begin
                  d.st = S_IDLE;
               end else if (op_bad(INSTR_DATA_I)) begin
                  d.st = S_HALT;
                  d.en = 1'b0;
                  ev[EV_BAD] = 1'b1;
               end else if (INSTR_DATA_I[F_OP_LSB +: 4] == OP_SKIP) begin
                  d.st = S_EXEC;
                  d.first = 1'b1;
               end else begin
                  d.st = S_FETCH1;
                  d.req = 1'b1;
               end
            end
         end
         S_FETCH1: begin
            if (INSTR_ACK_I) begin
               d.req = 1'b0;
               d.dw1 = INSTR_DATA_I;
               d.st = S_EXEC;
               d.first = 1'b1;
               if (op == OP_JUMP) begin
                  d.pc = jump_tgt;
               end else begin
                  d.pc = q.pc + PC_STEP;
               end
            end
         end
         S_EXEC: begin
            d.first = 1'b0;
            case (op)
               OP_SKIP, OP_PLANAR: begin
                  if (q.first) begin
                     if (q.abort) begin
                        // Aborted line: pass until flagged skip
                        d.abort = !q.dw0[F_LEND];
                        done = 1'b1;
                     end else if (op == OP_SKIP) begin
                        sk_start = 3'b001;
                     end else begin
                        sk_start = 3'b111;
                     end
                  end else if (|sk_early) begin
                     // Queue line end came before the count ran out
                     sk_flush = 1'b1;
                     d.abort = !q.dw0[F_LEND];
                     ev[EV_ABORT] = 1'b1;
                  end else if (&sk_idle) begin
                     done = 1'b1;
                  end
               end
               OP_SYNC: begin
                  if (sync_ready) begin
                     if (tag_hit) begin
                        done = 1'b1;
                     end else begin
                        sk_drop = 1'b1;
                        ev[EV_REALIGN] = !q.dw0[F_SUPP];
                     end
                  end
               end
               default: begin
                  done = 1'b1;
               end
            endcase
         end
         default: begin
            d.st = S_IDLE;
            d.req = 1'b0;
         end
      endcase

      // Completion of any instruction
      if (done) begin
         d.pstat = pstat_nx;
         ev[EV_INSTR] = q.dw0[F_IRQ];
         d.st = S_FETCH0;
         d.req = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         q <= '0;
         q.st <= S_IDLE;
         q.pc <= PC_RST;
         q.start <= PC_RST;
         q.mask <= MASK_RST;
         q.pstat <= PSTAT_RST;
      end else begin
         q <= d;
      end
   end

   // -----------------------------------------------------------
   // Queue discard engines
   // -----------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_queue
      queue_byte_skipper u_skip (
         .clk_i(REF_CLK_I),
         .rst_n_i(RST_N_I),
         .start_i(sk_start[g]),
         .cnt_i(sk_cnt[g]),
         .flush_i(sk_flush),
         .drop_i(drop_v[g]),
         .valid_i(Q_VALID_I[g]),
         .line_end_i(line_end_v[g]),
         .pop_o(Q_POP_O[g]),
         .early_o(sk_early[g]),
         .idle_o(sk_idle[g])
      );
   end

   // -----------------------------------------------------------
   // Interrupts
   // -----------------------------------------------------------
   event_flags #(
      .N(EV_N)
   ) u_events (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .set_i(ev),
      .clr_i(clr),
      .mask_i(q.mask),
      .stat_o(ev_stat),
      .irq_o(IRQ_O)
   );

   assign REG_RDATA_O = q.rdata;
   assign INSTR_REQ_O = q.req;
   assign INSTR_ADDR_O = q.pc;
   assign PROG_STATUS_O = q.pstat;

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_sync_miss;
      sync_ready && !tag_hit;
   endsequence
   sequence s_sync_hit;
      sync_ready && tag_hit;
   endsequence
   sequence s_skip_go;
      q.st == S_EXEC && q.first && !q.abort && op == OP_SKIP;
   endsequence
   sequence s_planar_go;
      q.st == S_EXEC && q.first && !q.abort && op == OP_PLANAR;
   endsequence
   a_sync_discard: assert property (
      s_sync_miss |=> Q_POP_O[0] && q.st == S_EXEC)
      else $error("sync miss did not discard a word");
   a_sync_match: assert property (
      s_sync_hit |=> q.st == S_FETCH0 && !Q_POP_O[0] && q.req)
      else $error("sync match did not finish");
   a_sync_quiet: assert property (
      s_sync_miss |=> ev_stat[EV_REALIGN] == ($past(ev_stat[EV_REALIGN])
      || !q.dw0[F_SUPP]) || $past(clr[EV_REALIGN]))
      else $error("realign error report wrong");
   a_skip_start: assert property (
      s_skip_go and (q.dw0[CNT_W-1:0] != '0) |=> !sk_idle[0]
      && sk_idle[2:1] == 2'b11)
      else $error("packed skip did not start luma only");
   a_planar_start: assert property (
      s_planar_go |=> (sk_idle[1] == (q.dw1[CNT_W-1:0] == '0))
      && (sk_idle[2] == (q.dw1[F_CNT3_LSB +: CNT_W] == '0))
      && (sk_idle[0] == (q.dw0[CNT_W-1:0] == '0)))
      else $error("planar counts not loaded");
   a_jump_load: assert property (
      q.st == S_FETCH1 && INSTR_ACK_I && op == OP_JUMP
      |=> q.pc == $past(jump_tgt) ##1 q.st == S_FETCH0)
      else $error("jump target not loaded");
   a_pc_step: assert property (
      q.st == S_FETCH0 && INSTR_ACK_I |=> q.pc == $past(q.pc) + PC_STEP)
      else $error("program counter did not step");
   a_bad_halt: assert property (
      q.st == S_FETCH0 && INSTR_ACK_I && q.en && op_bad(INSTR_DATA_I)
      |=> q.st == S_HALT && ev_stat[EV_BAD] && !q.en && !q.req)
      else $error("bad instruction did not halt");
   a_status_set: assert property (
      done |=> PROG_STATUS_O == $past(pstat_nx)
      && (ev_stat[EV_INSTR] || !$past(q.dw0[F_IRQ])))
      else $error("status pattern or interrupt missing");
   a_abort_pass: assert property (
      q.st == S_EXEC && q.first && q.abort && op_is_skip(q.dw0)
      |=> &sk_idle && q.st == S_FETCH0 && q.abort == !$past(q.dw0[F_LEND]))
      else $error("aborted skip was not passed over");
   a_irq_level: assert property (
      |(ev_stat & q.mask) |=> IRQ_O || $past(|clr))
      else $error("unmasked event without interrupt");
endmodule
`default_nettype wire

// [verif/instr_mem_model.sv]
// Host memory model answering instruction fetches
`timescale 1ns/1ps
`default_nettype none
module instr_mem_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic slow_i,
   input wire logic ld_i,
   input wire logic [5:0] ld_addr_i,
   input wire logic [31:0] ld_data_i,
   output logic ack_o,
   output logic [31:0] data_o
);
   logic [31:0] mem [64];
   int wait_q = 0;
   initial begin
      ack_o = 1'b0;
      data_o = 32'h0;
   end
   // One-cycle answer after a hold-off; idle data toggles every cycle
   always @(posedge clk_i) begin
      if (ld_i) begin
         mem[ld_addr_i] <= ld_data_i;
      end
      if (req_i && !ack_o && wait_q == 0) begin
         ack_o <= 1'b1;
         data_o <= mem[addr_i[7:2]];
         wait_q <= slow_i ? int'($urandom_range(3, 0)) : 0;
      end else begin
         ack_o <= 1'b0;
         data_o <= ~data_o;
         if (req_i && !ack_o) begin
            wait_q <= wait_q - 1;
         end
      end
   end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the skip, jump and sync decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import seq_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, instr_addr, instr_data;
   logic instr_req, instr_ack, irq;
   logic [2:0] q_valid = 3'h0;
   logic [2:0] q_pop;
   logic [3:0] luma_tag = 4'h0;
   logic luma_line_end = 1'b0;
   logic [3:0] prog_status;
   logic [3:0] sync_st = 4'h0;
   logic slow = 1'b0;
   logic ld = 1'b0;
   logic [5:0] ld_addr = 6'h0;
   logic [31:0] ld_data = 32'h0;
   logic [3:0] bad_ops [12] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6,
      4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   int sync_base = 0;
   int n_bad = 0;
   int pops [3] = '{0, 0, 0};
   int exp_pops [3] = '{0, 0, 0};
   int off [3] = '{0, 0, 0};

   always #2 clk = ~clk;

   seq_skip_jump_sync u_dut (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(reg_addr),
      .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
      .REG_RDATA_O(reg_rdata), .INSTR_REQ_O(instr_req),
      .INSTR_ADDR_O(instr_addr), .INSTR_ACK_I(instr_ack),
      .INSTR_DATA_I(instr_data), .Q_VALID_I(q_valid), .Q_POP_O(q_pop),
      .LUMA_TAG_I(luma_tag), .LUMA_LINE_END_I(luma_line_end),
      .PROG_STATUS_O(prog_status), .IRQ_O(irq)
   );
   instr_mem_model u_mem (
      .clk_i(clk), .req_i(instr_req), .addr_i(instr_addr), .slow_i(slow),
      .ld_i(ld), .ld_addr_i(ld_addr), .ld_data_i(ld_data),
      .ack_o(instr_ack), .data_o(instr_data)
   );

   // -----------------------------------------------------------
   // Queue side: random presence, pop counting, tag stream
   // -----------------------------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      q_valid <= 3'($urandom);
      for (int q = 0; q < 3; q++) begin
         if (q_pop[q] === 1'b1) begin
            pops[q] <= pops[q] + 1;
         end
      end
      // Wrong tags until the chosen number of words has gone
      if (pops[0] + int'(q_pop[0]) - sync_base < n_bad) begin
         luma_tag <= ~sync_st;
      end else begin
         luma_tag <= sync_st;
      end
      if (cycles > 60000) begin
         n_fail++;
         end_of_test();
      end
   end

   // -----------------------------------------------------------
   // Tasks and expectation helpers
   // -----------------------------------------------------------
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic load(input int idx, input logic [31:0] d);
      @(posedge clk);
      ld <= 1'b1;
      ld_addr <= 6'(idx);
      ld_data <= d;
      @(posedge clk);
      ld <= 1'b0;
   endtask
   task automatic drop(input int q, input int n);
      exp_pops[q] += (off[q] + n) / 4;
      off[q] = (off[q] + n) % 4;
   endtask
   function automatic logic [31:0] mk(input logic [3:0] op,
      input logic [15:0] low, input logic [7:0] pat, input logic irq_b);
      return {op, 3'h0, irq_b, pat, low};
   endfunction

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin : main
      logic [31:0] d, st;
      logic [3:0] ps, istat, mask;
      logic [7:0] pats [4];
      logic irqs [4];
      logic supp;
      int c1, c2, c3, c4;
      void'($urandom(32'h0bdc8097));
      ps = PSTAT_RST;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(REG_PC, d);
      chk("pc reset", PC_RST, d);
      @(posedge clk);
      #1 chk("rdata idle", 32'h0, reg_rdata);
      rd(REG_RUNSTAT, d);
      chk("runstat reset", 32'h0, d);
      rd(REG_IMASK, d);
      chk("mask reset", 32'(MASK_RST), d);
      st = 32'($urandom) & 32'hffff_fffc;
      wr(REG_START, st);
      rd(REG_START, d);
      chk("start rw", st, d);
      wr(8'hfc, 32'($urandom));
      rd(8'hfc, d);
      chk("unmapped", 32'h0, d);
      for (int i = 0; i < 13; i++) begin
         mask = 4'($urandom);
         slow <= 1'($urandom);
         luma_line_end <= (i == 11);
         sync_st = (i == 12) ? 4'hf : 4'($urandom_range(14, 0));
         n_bad = $urandom_range(3, 0);
         supp = 1'($urandom);
         sync_base = pops[0];
         c1 = $urandom_range(40, 1) + ((i == 11) ? 4 : 0);
         c2 = (i == 1) ? 4095 : (i == 11) ? 0 : $urandom_range(40, 1);
         c3 = (i == 11) ? 0 : $urandom_range(40, 1);
         c4 = 4 * $urandom_range(5, 1) + (4 - c1 % 4) % 4;
         for (int k = 0; k < 4; k++) begin
            pats[k] = 8'($urandom);
            irqs[k] = 1'($urandom);
         end
         load(0, mk(OP_SYNC, {supp, 11'h0, sync_st}, pats[0], irqs[0]));
         load(1, 32'h0);
         load(2, mk(OP_PLANAR, 16'(c1), pats[1], irqs[1]));
         load(3, {4'h0, 12'(c3), 4'h0, 12'(c2)});
         load(4, mk(OP_SKIP, 16'(c4), pats[2], irqs[2]));
         load(5, mk(OP_JUMP, 16'h0, pats[3], irqs[3]));
         load(6, 32'h80);
         load(32, {bad_ops[i % 12], 28'h0});
         istat = 4'h0;
         istat[EV_BAD] = 1'b1;
         if (i < 12) begin
            exp_pops[0] += n_bad;
            drop(1, c2);
            drop(2, c3);
            if (i == 11) begin
               // Line end cuts the planar skip after one luma word
               exp_pops[0] += 1;
               istat[EV_ABORT] = 1'b1;
            end else begin
               drop(0, c1);
               drop(0, c4);
            end
            for (int k = 0; k < 4; k++) begin
               ps = (ps & ~pats[k][3:0]) | pats[k][7:4];
               istat[EV_INSTR] |= irqs[k];
            end
            istat[EV_REALIGN] = n_bad > 0 && !supp;
         end
         wr(REG_IMASK, 32'(mask));
         wr(REG_START, 32'h0);
         wr(REG_CTRL, 32'h1);
         repeat (4) @(posedge clk);
         d = 32'h0;
         for (int t = 0; t < 3000 && d[RS_HALT] !== 1'b1; t++) begin
            rd(REG_RUNSTAT, d);
         end
         chk("runstat", 32'(ps) | (32'h1 << RS_HALT), d);
         chk("status out", 32'(ps), 32'(prog_status));
         chk("luma pops", exp_pops[0], pops[0]);
         chk("b pops", exp_pops[1], pops[1]);
         chk("r pops", exp_pops[2], pops[2]);
         rd(REG_PC, d);
         if (i < 12) begin
            chk("pc", 32'h84, d);
         end
         rd(REG_ISTAT, d);
         chk("events", 32'(istat), d);
         chk("irq", 32'(|(istat & mask)), 32'(irq));
         rd(REG_CTRL, d);
         chk("enable cleared", 32'h0, d);
         wr(REG_ISTAT, 32'hf);
         rd(REG_ISTAT, d);
         chk("events cleared", 32'h0, d);
         chk("irq cleared", 32'h0, 32'(irq));
      end
      end_of_test();
   end
endmodule
`default_nettype wire
